// ### design/corc_defines.vh
`ifndef CORC_DEFINES_VH
`define CORC_DEFINES_VH

// Register addresses on the internal serial-core port
`define CORC_ADDR_SENSE_MUX     6'h06
`define CORC_ADDR_OUT_SWITCH    6'h07
`define CORC_ADDR_RESTART_CH01  6'h08
`define CORC_ADDR_LATCHOFF      6'h32

// Field positions
`define CORC_SENSE_EN_BIT       3
`define CORC_SENSE_SEL_MSB      2
`define CORC_SENSE_SEL_LSB      0
`define CORC_RESTART_CH0_MSB    3
`define CORC_RESTART_CH0_LSB    0
`define CORC_RESTART_CH1_MSB    7
`define CORC_RESTART_CH1_LSB    4

// Reset values
`define CORC_SENSE_MUX_RST      4'h0
`define CORC_OUT_SWITCH_RST     4'h0
`define CORC_RESTART_RST        8'h00

// Restart codes
`define CORC_CODE_LATCHOFF      4'h0
`define CORC_CODE_FAILSAFE_MIN  4'h1

// Timing: blanking step of 17 ms at a 40 MHz clock
`define CORC_CLK_KHZ            40000
`define CORC_BLANK_STEP_MS      17
`define CORC_BLANK_STEP_CYC     (`CORC_BLANK_STEP_MS * `CORC_CLK_KHZ)

`endif

// ### design/corc_blank_timer.v
`timescale 1ns/1ps
`default_nettype none

// One channel's blanking window: code steps of STEP_CYC cycles each
module corc_blank_timer #(
    parameter integer STEP_CYC = 680000,
    parameter integer PW       = 20
) (
    // Clock and reset
    input  wire       clk,
    input  wire       rst,
    // Control
    input  wire       start,
    input  wire [3:0] code,
    // Status
    output reg        busy,
    output reg        done
);

    // Cut to the prescaler width on purpose; PW must cover STEP_CYC
    localparam [31:0]   STEP_LAST_W = STEP_CYC - 1;
    localparam [PW-1:0] STEP_LAST   = STEP_LAST_W[PW-1:0];

    reg [PW-1:0] presc_r;
    reg [3:0]    steps_r;

    ////////////////////////////////////////////////////////////////////////
    // Restart on start even while busy, so a new fault opens a full window
    always @(posedge clk) begin
        if (rst) begin
            busy    <= 1'b0;
            done    <= 1'b0;
            presc_r <= {PW{1'b0}};
            steps_r <= 4'h0;
        end else begin
            done <= 1'b0;
            if (start && code != 4'h0) begin
                busy    <= 1'b1;
                presc_r <= STEP_LAST;
                steps_r <= code;
            end else if (busy) begin
                if (presc_r != {PW{1'b0}}) begin
                    presc_r <= presc_r - 1'b1;
                end else if (steps_r == 4'h1) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    presc_r <= STEP_LAST;
                    steps_r <= steps_r - 1'b1;
                end
            end
        end
    end

endmodule

`default_nettype wire

// ### design/corc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "corc_defines.vh"

module corc_top #(
    parameter integer NCH      = 4,
    parameter integer STEP_CYC = `CORC_BLANK_STEP_CYC,
    parameter integer PW       = 20
) (
    // Clock and reset
    input  wire           clk,
    input  wire           rst,
    // Register port from the serial core
    input  wire           reg_wr,
    input  wire           reg_rd,
    input  wire [5:0]     reg_addr,
    input  wire [7:0]     reg_wdata,
    output reg  [7:0]     reg_rdata,
    // Mode state from the mode controller
    input  wire           normal_mode,
    // Channel 2/3 restart register, held elsewhere
    input  wire [7:0]     restart_blank_ch2_ch3,
    input  wire           restart_ch23_wr,
    // Fail-safe direct input levels
    input  wire [NCH-1:0] direct_in,
    // Protection: event pulse and present level per channel
    input  wire [NCH-1:0] fault_event,
    input  wire [NCH-1:0] fault_present,
    // Channel drive
    output reg  [NCH-1:0] out_on,
    // Sense multiplexer
    output reg            sense_output_enable,
    output reg  [NCH-1:0] sense_route,
    // Latch-off status
    output reg  [NCH-1:0] latchoff_flags,
    // Register contents for the rest of the device
    output reg  [3:0]     sense_mux_q,
    output reg  [3:0]     output_switch_q,
    output reg  [7:0]     restart_blank_ch01_q
);

    // Channel states
    localparam [1:0] CH_RUN   = 2'h0;
    localparam [1:0] CH_BLANK = 2'h1;
    localparam [1:0] CH_LATCH = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    // One-hot route for a select code; reserved codes give no channel
    function [3:0] sel_onehot;
        input [2:0] sel;
        begin
            case (sel)
                3'h0:    sel_onehot = 4'h1;
                3'h1:    sel_onehot = 4'h2;
                3'h2:    sel_onehot = 4'h4;
                3'h3:    sel_onehot = 4'h8;
                default: sel_onehot = 4'h0;
            endcase
        end
    endfunction

    // Restart code of channel n from the two restart registers
    function [3:0] chan_code;
        input [7:0] r01;
        input [7:0] r23;
        input integer n;
        begin
            case (n)
                0:       chan_code = r01[`CORC_RESTART_CH0_MSB:
                                         `CORC_RESTART_CH0_LSB];
                1:       chan_code = r01[`CORC_RESTART_CH1_MSB:
                                         `CORC_RESTART_CH1_LSB];
                2:       chan_code = r23[3:0];
                default: chan_code = r23[7:4];
            endcase
        end
    endfunction

    // Window code; fail-safe never latches, so zero becomes one step
    function [3:0] window_code;
        input [3:0] code;
        input       normal;
        begin
            if (!normal && code == `CORC_CODE_LATCHOFF) begin
                window_code = `CORC_CODE_FAILSAFE_MIN;
            end else begin
                window_code = code;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register writes

    wire wr_sense   = reg_wr && reg_addr == `CORC_ADDR_SENSE_MUX;
    wire wr_switch  = reg_wr && reg_addr == `CORC_ADDR_OUT_SWITCH;
    wire wr_restart = reg_wr && reg_addr == `CORC_ADDR_RESTART_CH01;

    // Reserved upper bits are not stored and read back as zero
    always @(posedge clk) begin
        if (rst) begin
            sense_mux_q          <= `CORC_SENSE_MUX_RST;
            output_switch_q      <= `CORC_OUT_SWITCH_RST;
            restart_blank_ch01_q <= `CORC_RESTART_RST;
        end else begin
            if (wr_sense) begin
                sense_mux_q <= reg_wdata[3:0];
            end
            if (wr_switch) begin
                output_switch_q <= reg_wdata[3:0];
            end
            if (wr_restart) begin
                restart_blank_ch01_q <= reg_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads, answered one cycle after the read strobe

    always @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `CORC_ADDR_SENSE_MUX:    reg_rdata <= {4'h0, sense_mux_q};
                `CORC_ADDR_OUT_SWITCH:   reg_rdata <= {4'h0, output_switch_q};
                `CORC_ADDR_RESTART_CH01: reg_rdata <= restart_blank_ch01_q;
                `CORC_ADDR_LATCHOFF:     reg_rdata <= {4'h0, latchoff_flags};
                default:                 reg_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sense multiplexer; registered so the analog switch sees no glitch

    wire [2:0] sense_sel = sense_mux_q[`CORC_SENSE_SEL_MSB:
                                       `CORC_SENSE_SEL_LSB];
    wire       sense_on  = sense_mux_q[`CORC_SENSE_EN_BIT];
    wire       sense_sel_valid = (sel_onehot(sense_sel) != 4'h0);

    always @(posedge clk) begin
        if (rst) begin
            sense_output_enable <= 1'b0;
            sense_route         <= {NCH{1'b0}};
        end else begin
            // Reserved select codes leave the pin undriven
            sense_output_enable <= sense_on && sense_sel_valid;
            sense_route <= sense_on ? sel_onehot(sense_sel)
                                    : {NCH{1'b0}};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-channel clear strobes: a write clears even with the same value

    wire [NCH-1:0] clear_latch;
    assign clear_latch[0] = wr_restart;
    assign clear_latch[1] = wr_restart;
    assign clear_latch[2] = restart_ch23_wr;
    assign clear_latch[3] = restart_ch23_wr;

    ////////////////////////////////////////////////////////////////////////
    // Blanking timers, one per channel

    reg  [1:0]     st_r [0:NCH-1];
    reg  [NCH-1:0] tmr_start;
    reg  [3:0]     tmr_code [0:NCH-1];
    wire [NCH-1:0] tmr_busy;
    wire [NCH-1:0] tmr_done;

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_tmr
            corc_blank_timer #(
                .STEP_CYC (STEP_CYC),
                .PW       (PW)
            ) u_tmr (
                .clk   (clk),
                .rst   (rst),
                .start (tmr_start[g]),
                .code  (tmr_code[g]),
                .busy  (tmr_busy[g]),
                .done  (tmr_done[g])
            );
        end
    endgenerate

    // Timer start and window length for each channel
    integer k;
    always @* begin
        for (k = 0; k < NCH; k = k + 1) begin
            tmr_code[k]  = window_code(chan_code(restart_blank_ch01_q,
                                restart_blank_ch2_ch3, k),
                                normal_mode);
            tmr_start[k] = fault_event[k] && tmr_code[k] != 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel protection state

    // A fault event wins over a clear arriving in the same cycle
    integer i;
    always @(posedge clk) begin
        if (rst) begin
            for (i = 0; i < NCH; i = i + 1) begin
                st_r[i] <= CH_RUN;
            end
        end else begin
            for (i = 0; i < NCH; i = i + 1) begin
                case (st_r[i])
                    CH_RUN: begin
                        if (fault_event[i]) begin
                            // Code zero in Normal mode: no window at all
                            if (tmr_code[i] == `CORC_CODE_LATCHOFF) begin
                                st_r[i] <= CH_LATCH;
                            end else begin
                                st_r[i] <= CH_BLANK;
                            end
                        end
                    end
                    CH_BLANK: begin
                        if (fault_event[i]) begin
                            st_r[i] <= CH_BLANK;
                        end else if (tmr_done[i]) begin
                            // Fail-safe retries whatever the fault level
                            if (normal_mode && fault_present[i]) begin
                                st_r[i] <= CH_LATCH;
                            end else begin
                                st_r[i] <= CH_RUN;
                            end
                        end else if (!tmr_busy[i] && !tmr_start[i]) begin
                            st_r[i] <= CH_RUN;
                        end
                    end
                    CH_LATCH: begin
                        if (!normal_mode) begin
                            // Latch-off settings do not hold in fail-safe
                            st_r[i] <= tmr_start[i] ? CH_BLANK
                                                    : CH_RUN;
                        end else if (clear_latch[i]) begin
                            if (fault_event[i]) begin
                                st_r[i] <= (tmr_code[i] ==
                                            `CORC_CODE_LATCHOFF)
                                           ? CH_LATCH : CH_BLANK;
                            end else begin
                                st_r[i] <= CH_RUN;
                            end
                        end
                    end
                    default: begin
                        st_r[i] <= CH_RUN;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Drive and latch-off flags

    // Fail-safe drive follows direct inputs; protection still gates both
    integer j;
    always @(posedge clk) begin
        if (rst) begin
            out_on         <= {NCH{1'b0}};
            latchoff_flags <= {NCH{1'b0}};
        end else begin
            for (j = 0; j < NCH; j = j + 1) begin
                out_on[j] <= (st_r[j] == CH_RUN) &&
                             (normal_mode ? output_switch_q[j]
                                          : direct_in[j]);
                latchoff_flags[j] <= (st_r[j] == CH_LATCH);
            end
        end
    end

    // Mode entry is the host's two-write sequence; only its result is seen
    // here as normal_mode.

endmodule

`default_nettype wire

// ### tb/corc_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module corc_top_chk #(
    parameter integer NCH = 4
) (
    // Clock and reset
    input wire logic           clk,
    input wire logic           rst,
    // Register port
    input wire logic           reg_wr,
    input wire logic           reg_rd,
    input wire logic [5:0]     reg_addr,
    input wire logic [7:0]     reg_wdata,
    input wire logic [7:0]     reg_rdata,
    // Mode and protection
    input wire logic           normal_mode,
    input wire logic [NCH-1:0] fault_event,
    // Watched outputs
    input wire logic [NCH-1:0] out_on,
    input wire logic [NCH-1:0] sense_route,
    input wire logic [NCH-1:0] latchoff_flags,
    input wire logic [3:0]     sense_mux_q,
    input wire logic [3:0]     output_switch_q,
    input wire logic [7:0]     restart_blank_ch01_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Write to the channel 0/1 restart register, also the latch clear
    wire clr01 = reg_wr && reg_addr == 6'h08;
    ////////////////////////////////////////////////////////////////
    property p_sense_off;
        !sense_mux_q[3] |=> sense_route == 0;
    endproperty
    a_sense_off: assert property (p_sense_off)
        else $error("sense routed while disabled");
    property p_sense_sel;
        sense_mux_q[3] |=> sense_route == ($past(sense_mux_q[2]) ? 4'h0
            : 4'h1 << $past(sense_mux_q[1:0]));
    endproperty
    a_sense_sel: assert property (p_sense_sel)
        else $error("wrong sense channel");
    property p_sw_wr;
        reg_wr && reg_addr == 6'h07 |=>
            output_switch_q == $past(reg_wdata[3:0]);
    endproperty
    a_sw_wr: assert property (p_sw_wr)
        else $error("output control not stored");
    property p_evt_off;
        normal_mode && fault_event[0] ##1 normal_mode |-> ##1 !out_on[0];
    endproperty
    a_evt_off: assert property (p_evt_off)
        else $error("channel not cut after fault");
    property p_latch;
        normal_mode && fault_event[0] && restart_blank_ch01_q[3:0] == 4'h0
            |-> ##2 latchoff_flags[0];
    endproperty
    a_latch: assert property (p_latch)
        else $error("code zero did not latch");
    property p_clear;
        clr01 && !fault_event[0] |-> ##2 !latchoff_flags[0];
    endproperty
    a_clear: assert property (p_clear)
        else $error("latch not cleared by write");
    // Three quiet cycles cover the state-to-flag lag
    property p_hold;
        (latchoff_flags[0] && normal_mode && !clr01) [*3] |=>
            latchoff_flags[0];
    endproperty
    a_hold: assert property (p_hold)
        else $error("latch released without write");
    property p_rd_flags;
        reg_rd && reg_addr == 6'h32 |=>
            reg_rdata == {4'h0, $past(latchoff_flags)};
    endproperty
    a_rd_flags: assert property (p_rd_flags)
        else $error("latch flags read wrong");
    property p_rst_code;
        $fell(rst) |-> restart_blank_ch01_q == 8'h00 && latchoff_flags == 0;
    endproperty
    a_rst_code: assert property (p_rst_code)
        else $error("restart codes not zero after reset");
    property p_r01_wr;
        clr01 |=> restart_blank_ch01_q == $past(reg_wdata);
    endproperty
    a_r01_wr: assert property (p_r01_wr)
        else $error("restart register not stored");
    // Main scenarios reached
    c_latch: cover property (latchoff_flags[0] ##1 !latchoff_flags[0]);
    c_sense: cover property (sense_route[3]);
    c_retry: cover property (!out_on[1] [*8] ##1 out_on[1]);
endmodule
bind corc_top corc_top_chk #(.NCH(NCH)) u_chk (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .normal_mode(normal_mode), .fault_event(fault_event),
    .out_on(out_on), .sense_route(sense_route),
    .latchoff_flags(latchoff_flags), .sense_mux_q(sense_mux_q),
    .output_switch_q(output_switch_q),
    .restart_blank_ch01_q(restart_blank_ch01_q));
`default_nettype wire

// ### tb/corc_host.sv
`timescale 1ns/1ps
`default_nettype none
module corc_host (
    // Clock
    input  wire logic       clk,
    // Register port towards the block
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [5:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    // Mode state
    output var  logic       normal_mode
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        normal_mode = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // One-cycle strobe; released lines flip so stale values never match
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // Read data is registered, taken one cycle after the strobe
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
    // Unlock first, then enable with standby request clear
    task automatic go_normal;
        wr(6'h00, 8'h10);
        wr(6'h00, 8'h01);
        normal_mode = 1'b1;
    endtask
    task automatic go_failsafe;
        @(negedge clk);
        normal_mode = 1'b0;
    endtask
endmodule
`default_nettype wire

// ### tb/test_channel_output_restart_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_channel_output_restart_control;
    logic clk, rst, rd_s, wr_s, nm, sen, c23_wr;
    logic [5:0] addr;
    logic [7:0] wd, rdat, r23, r01_q;
    logic [3:0] din, fev, fpr, out_on, route, flags, smux_q, sw_q;
    int errors = 0;
    int num_checks = 0;
    // Short blanking step keeps the windows a few cycles long
    corc_top #(.STEP_CYC(4)) dut (
        .clk(clk), .rst(rst), .reg_wr(wr_s), .reg_rd(rd_s),
        .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdat),
        .normal_mode(nm), .restart_blank_ch2_ch3(r23),
        .restart_ch23_wr(c23_wr), .direct_in(din), .fault_event(fev),
        .fault_present(fpr), .out_on(out_on), .sense_output_enable(sen),
        .sense_route(route), .latchoff_flags(flags),
        .sense_mux_q(smux_q), .output_switch_q(sw_q),
        .restart_blank_ch01_q(r01_q));
    corc_host u_host (
        .clk(clk), .reg_wr(wr_s), .reg_rd(rd_s), .reg_addr(addr),
        .reg_wdata(wd), .reg_rdata(rdat), .normal_mode(nm));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Single-cycle fault pulse on the channels in m
    task automatic evt(input logic [3:0] m);
        @(negedge clk);
        fev = m;
        @(negedge clk);
        fev = 4'h0;
    endtask
    task automatic t_reset;
        logic [7:0] d;
        u_host.rd(6'h08, d);
        chk(d, 8'h00);
        u_host.rd(6'h32, d);
        chk(d, 8'h00);
    endtask
    task automatic t_sense;
        logic [7:0] d;
        logic [7:0] e;
        for (int s = 0; s < 8; s++) begin
            u_host.wr(6'h06, 8'hf8 | s[7:0]);
            cyc(1);
            // Enable bit 4 of the compare word, one-hot route below it
            e = s < 4 ? 8'h10 | (8'h1 << s) : 8'h00;
            chk({3'h0, sen, route}, e);
            u_host.rd(6'h06, d);
            chk(d, 8'h08 | s[7:0]);
        end
        u_host.wr(6'h06, 8'h01);
        cyc(1);
        chk({sen, route}, 8'h00);
    endtask
    task automatic t_switch;
        logic [7:0] d;
        u_host.wr(6'h07, 8'hf5);
        cyc(1);
        chk(out_on, 8'h05);
        u_host.rd(6'h07, d);
        chk(d, 8'h05);
        u_host.wr(6'h07, 8'h0a);
        cyc(1);
        chk(out_on, 8'h0a);
        u_host.rd(6'h3f, d);
        chk(d, 8'h00);
        u_host.wr(6'h07, 8'h0f);
    endtask
    // Latched channel stays off until its own clear arrives
    task automatic t_latch;
        logic [7:0] d;
        fpr = 4'h1;
        evt(4'h1);
        cyc(1);
        chk(out_on, 8'h0e);
        chk(flags, 8'h01);
        evt(4'h8);
        cyc(10);
        chk(flags, 8'h09);
        u_host.rd(6'h32, d);
        chk(d, 8'h09);
        fpr = 4'h0;
        u_host.wr(6'h08, 8'h00);
        cyc(1);
        chk(out_on, 8'h07);
        c23_wr = 1'b1;
        cyc(1);
        c23_wr = 1'b0;
        cyc(1);
        chk(out_on, 8'h0f);
        chk(flags, 8'h00);
    endtask
    // Code 3 on channel 1: three 4-cycle steps, then state and drive lag
    task automatic t_restart;
        u_host.wr(6'h08, 8'h30);
        evt(4'h2);
        cyc(13);
        chk(out_on, 8'h0d);
        cyc(1);
        chk(out_on, 8'h0f);
        fpr = 4'h2;
        evt(4'h2);
        cyc(16);
        chk(flags, 8'h02);
        chk(out_on, 8'h0d);
        fpr = 4'h0;
    endtask
    // Fail-safe retries forever, even with the fault still present
    task automatic t_failsafe;
        u_host.go_failsafe;
        din = 4'h4;
        fpr = 4'h4;
        cyc(2);
        chk(out_on, 8'h04);
        repeat (3) begin
            evt(4'h4);
            cyc(1);
            chk(out_on, 8'h00);
            cyc(6);
            chk({flags, out_on}, 8'h04);
        end
    endtask
    task automatic tally_and_finish;
        if (errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        tally_and_finish;
    end
    initial begin
        rst = 1'b1;
        c23_wr = 1'b0;
        r23 = 8'h00;
        din = 4'h0;
        fev = 4'h0;
        fpr = 4'h0;
        cyc(2);
        rst = 1'b0;
        t_reset;
        u_host.go_normal;
        t_sense;
        t_switch;
        t_latch;
        t_restart;
        t_failsafe;
        tally_and_finish;
    end
endmodule
`default_nettype wire
